// File: core/sdc_pkg.sv
/*
  Shared constants, command codes and carrier types for the SDRAM command
  execution core. Assumes a single 40 MHz clock shared with the controller.
*/
package sdc_pkg;

  localparam int unsigned CLK_FREQ_KHZ = 40000;
  // self refresh spreads 4096 refreshes over 64 ms: one every 15625 ns
  localparam int unsigned SREF_INTERVAL_NS = 15625;
  localparam int unsigned SREF_TICK_CYC = SREF_INTERVAL_NS * CLK_FREQ_KHZ / 1000000;
  localparam int unsigned TICK_W = $clog2(SREF_TICK_CYC);

  localparam int unsigned BANKS = 4;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned COL_W = 8;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned BYTES = 2;
  localparam int unsigned REF_W = BANK_W + ROW_W;
  localparam int unsigned MEM_DEPTH = BANKS * (1 << COL_W);
  localparam int unsigned LEN_W = COL_W + 1;

  localparam int unsigned AUTO_CLOSE_BIT = 10;
  localparam logic [ROW_W-1:0] MODE_RST = 12'h000;

  // burst length field, mode register bits 2:0
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  typedef enum logic [3:0] {
    CMD_INH, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_MRS
  } sdc_cmd_t;

  typedef enum logic {SDC_RUN, SDC_SREF} sdc_mode_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] addr;
    logic [BYTES-1:0] dqm;
    logic [DQ_W-1:0] dq;
  } sdc_pins_t;

  localparam sdc_pins_t PINS_IDLE = sdc_pins_t'{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
    we_n: 1'b1, default: '0};

  typedef struct packed {
    logic valid;
    logic [BYTES-1:0] mask;
    logic [DQ_W-1:0] data;
  } sdc_rd_t;

  typedef struct packed {
    logic open;
    logic [ROW_W-1:0] row;
  } sdc_bank_t;

  function automatic sdc_cmd_t sdc_decode(input sdc_pins_t p);
    sdc_cmd_t c;
    c = CMD_INH;
    if (!p.cs_n)
    begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_RD;
        3'h4: c = CMD_WR;
        3'h6: c = CMD_BST;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REF;
        default: c = CMD_MRS;
      endcase
    end
    return c;
  endfunction : sdc_decode

  function automatic logic [LEN_W-1:0] sdc_burst_len(input logic [2:0] code);
    logic [LEN_W-1:0] n;
    case (code)
      BL_2: n = 9'h002;
      BL_4: n = 9'h004;
      BL_8: n = 9'h008;
      BL_PAGE: n = 9'h100;
      default: n = 9'h001;
    endcase
    return n;
  endfunction : sdc_burst_len

endpackage : sdc_pkg

// File: core/sdc_bank.sv
/*
  One bank's row state: idle or open with a latched row address.
  Assumes open and close strobes come from the command core on the same clock.
*/
`timescale 1ns/1ps
module sdc_bank
  import sdc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // strobes from the command core
  input wire logic open_i,
  input wire logic close_i,
  input wire logic [ROW_W-1:0] row_i,
  // state
  output logic open_q,
  output logic [ROW_W-1:0] row_q
);

  sdc_bank_t s_q;
  sdc_bank_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (open_i)
    begin
      s_d.open = 1'b1;
      s_d.row = row_i;
    end
    else if (close_i)
    begin
      s_d.open = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign open_q = s_q.open;
  assign row_q = s_q.row;

endmodule : sdc_bank

// File: core/sdc_core.sv
/*
  Command execution core of a four-bank SDRAM: decode, bursts, byte masks,
  precharge, refresh, self refresh and mode register load.
  Assumes the controller drives pins from the same clock; pins and the
  asynchronous clock enable all pass two flip-flops before use.
*/
`timescale 1ns/1ps
// Overview of operation
// - read takes bank from bank-select inputs, column from address 7:0, bursts open row
// - auto_close_address_bit high on read closes row after burst, else row stays open
// - read byte mask high floats that lane two clocks later, low drives data
// - write takes bank and column likewise; auto-close bit decides closing after burst
// - write mask applies with its data; masked bytes leave memory unchanged
// - precharge closes one bank or all banks
// - auto_close_address_bit high selects all banks, low the bank-select bank
// - auto close chosen per access, bank closed at burst end without command
// - auto refresh uses internal row and bank counter, ignores address
// - refresh code is auto refresh with clock enable high, self refresh when low
// - self refresh starts as clock enable falls; all other inputs ignored then
// - self refresh continues on internal timing while clock enable stays low
// - burst terminate cuts the latest read or write burst, any length
// - chip select high accepts no command, running bursts continue
// - no-operation registers no command
// - mode register load copies address 11:0; only when all banks idle (the core loads it whatever the bank state)
// - activate opens the given row in the selected bank until precharge
// - commands are decoded from chip select, row, column and write strobes
module sdc_core
  import sdc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller pins
  input wire logic cke,
  input wire sdc_pins_t pins,
  // data output lanes
  output logic [DQ_W-1:0] dq_o,
  output logic [BYTES-1:0] dq_oe,
  // status
  output logic [BANKS-1:0] bank_open,
  output logic sref_active,
  output logic [ROW_W-1:0] mode_reg,
  output logic [REF_W-1:0] refresh_addr
);

  typedef struct packed {
    sdc_pins_t pin_s1;
    sdc_pins_t pin_s2;
    logic cke_s1;
    logic cke_s2;
    logic cke_prev;
    sdc_mode_t mode;
    logic [ROW_W-1:0] mode_reg;
    logic bst_act;
    logic bst_wr;
    logic bst_close;
    logic [BANK_W-1:0] bst_bank;
    logic [COL_W-1:0] bst_col;
    logic [LEN_W-1:0] bst_left;
    logic [REF_W-1:0] ref_cnt;
    logic [TICK_W-1:0] tick;
    sdc_rd_t rd1;
    logic [DQ_W-1:0] out_data;
    logic [BYTES-1:0] out_oe;
  } sdc_state_t;

  sdc_state_t s_q;
  sdc_state_t s_d;
  logic [DQ_W-1:0] mem [0:MEM_DEPTH-1];
  logic [BANKS-1:0] act_v;
  logic [BANKS-1:0] close_v;
  logic [ROW_W-1:0] bank_row [0:BANKS-1];
  logic wr_en;
  logic [BYTES-1:0] wr_be;
  logic [$clog2(MEM_DEPTH)-1:0] acc_idx;
  sdc_cmd_t cmd;
  logic beat;
  logic b_wr;
  logic b_close;
  logic [BANK_W-1:0] b_bank;
  logic [COL_W-1:0] b_col;
  logic [LEN_W-1:0] b_left;
  logic [COL_W-1:0] wrap_m;

  // per-bank row state
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++)
    begin : g_bank
      sdc_bank u_bank (
        .clk(clk),
        .rst(rst),
        .open_i(act_v[gb]),
        .close_i(close_v[gb]),
        .row_i(s_q.pin_s2.addr),
        .open_q(bank_open[gb]),
        .row_q(bank_row[gb])
      );
    end
  endgenerate

  always_comb
  begin
    s_d = s_q;
    act_v = '0;
    close_v = '0;
    wr_en = 1'b0;
    wr_be = '0;
    s_d.pin_s1 = pins;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.cke_s1 = cke;
    s_d.cke_s2 = s_q.cke_s1;
    s_d.cke_prev = s_q.cke_s2;
    s_d.rd1 = '0;
    cmd = sdc_decode(s_q.pin_s2);
    beat = s_q.bst_act;
    b_wr = s_q.bst_wr;
    b_close = s_q.bst_close;
    b_bank = s_q.bst_bank;
    b_col = s_q.bst_col;
    b_left = s_q.bst_left;
    case (s_q.mode)
      SDC_RUN:
      begin
        s_d.tick = '0;
        case (cmd)
          CMD_ACT: act_v[s_q.pin_s2.ba] = 1'b1;
          CMD_RD, CMD_WR:
          begin
            // an access to an idle bank is dropped
            if (bank_open[s_q.pin_s2.ba])
            begin
              beat = 1'b1;
              b_wr = (cmd == CMD_WR);
              b_bank = s_q.pin_s2.ba;
              b_col = s_q.pin_s2.addr[COL_W-1:0];
              b_left = sdc_burst_len(s_q.mode_reg[2:0]);
              b_close = s_q.pin_s2.addr[AUTO_CLOSE_BIT];
            end
          end
          CMD_BST: beat = 1'b0;
          CMD_PRE:
          begin
            if (s_q.pin_s2.addr[AUTO_CLOSE_BIT])
            begin
              close_v = '1;
              beat = 1'b0;
            end
            else
            begin
              close_v[s_q.pin_s2.ba] = 1'b1;
              if (s_q.pin_s2.ba == s_q.bst_bank)
              begin
                beat = 1'b0;
              end
            end
          end
          CMD_REF:
          begin
            if (s_q.cke_s2)
            begin
              s_d.ref_cnt = s_q.ref_cnt + 14'h0001;
            end
            else if (s_q.cke_prev)
            begin
              s_d.mode = SDC_SREF;
              beat = 1'b0;
            end
          end
          CMD_MRS: s_d.mode_reg = s_q.pin_s2.addr;
          // inhibit and no-op leave state alone; bursts carry on
          default: ;
        endcase
      end
      SDC_SREF:
      begin
        // pins are ignored here; only the clock enable is watched
        beat = 1'b0;
        if (s_q.tick == TICK_W'(SREF_TICK_CYC - 1))
        begin
          s_d.tick = '0;
          s_d.ref_cnt = s_q.ref_cnt + 14'h0001;
        end
        else
        begin
          s_d.tick = s_q.tick + 10'h001;
        end
        if (s_q.cke_s2)
        begin
          s_d.mode = SDC_RUN;
        end
      end
      default: s_d.mode = SDC_RUN;
    endcase
    // sequential wrap inside an aligned block of the burst length
    wrap_m = COL_W'(sdc_burst_len(s_q.mode_reg[2:0]) - 9'h001);
    acc_idx = {b_bank, b_col};
    s_d.bst_act = 1'b0;
    if (beat)
    begin
      if (b_wr)
      begin
        wr_en = 1'b1;
        wr_be = ~s_q.pin_s2.dqm;
      end
      else
      begin
        s_d.rd1.valid = 1'b1;
        s_d.rd1.mask = s_q.pin_s2.dqm;
        s_d.rd1.data = mem[acc_idx];
      end
      if (b_left == 9'h001)
      begin
        if (b_close)
        begin
          close_v[b_bank] = 1'b1;
        end
      end
      else
      begin
        s_d.bst_act = 1'b1;
        s_d.bst_left = b_left - 9'h001;
        s_d.bst_col = (b_col & ~wrap_m) | ((b_col + 8'h01) & wrap_m);
        s_d.bst_bank = b_bank;
        s_d.bst_wr = b_wr;
        s_d.bst_close = b_close;
      end
    end
    // second read stage: data lanes float where the mask was high
    s_d.out_data = s_q.rd1.data;
    s_d.out_oe = {BYTES{s_q.rd1.valid}} & ~s_q.rd1.mask;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.pin_s1 <= PINS_IDLE;
      s_q.pin_s2 <= PINS_IDLE;
      s_q.mode_reg <= MODE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // array has no reset: contents are undefined until written, like the cells
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      for (int i = 0; i < BYTES; i++)
      begin
        if (wr_be[i])
        begin
          mem[acc_idx][i*8 +: 8] <= s_q.pin_s2.dq[i*8 +: 8];
        end
      end
    end
  end

  assign dq_o = s_q.out_data;
  assign dq_oe = s_q.out_oe;
  assign sref_active = (s_q.mode == SDC_SREF);
  assign mode_reg = s_q.mode_reg;
  assign refresh_addr = s_q.ref_cnt;

  property p_rd_float;
    @(posedge clk) disable iff (rst)
    (beat && !b_wr && s_q.pin_s2.dqm[0]) |-> ##2 !dq_oe[0];
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("masked read lane driven");

  property p_rd_drive;
    @(posedge clk) disable iff (rst)
    (beat && !b_wr && !s_q.pin_s2.dqm[1]) |-> ##2 dq_oe[1];
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("unmasked read lane idle");

  property p_act_open;
    @(posedge clk) disable iff (rst)
    (!sref_active && cmd == CMD_ACT && s_q.pin_s2.ba == 2'h2) |=> bank_open[2];
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate left bank idle");

  property p_pre_all;
    @(posedge clk) disable iff (rst)
    (!sref_active && cmd == CMD_PRE && s_q.pin_s2.addr[AUTO_CLOSE_BIT]) |=> bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_mrs;
    @(posedge clk) disable iff (rst)
    (!sref_active && cmd == CMD_MRS) |=> mode_reg == $past(s_q.pin_s2.addr);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode register not loaded");

  property p_ref_step;
    @(posedge clk) disable iff (rst)
    (!sref_active && cmd == CMD_REF && s_q.cke_s2)
      |=> refresh_addr == $past(refresh_addr) + 14'h0001;
  endproperty
  a_ref_step: assert property (p_ref_step) else $error("auto refresh did not advance");

  property p_sref_in;
    @(posedge clk) disable iff (rst)
    (!sref_active && cmd == CMD_REF && !s_q.cke_s2 && s_q.cke_prev) |=> sref_active ##1 !s_q.bst_act;
  endproperty
  a_sref_in: assert property (p_sref_in) else $error("self refresh not entered");

  property p_sref_hold;
    @(posedge clk) disable iff (rst)
    (sref_active && !s_q.cke_s2) |=> sref_active && $stable(mode_reg) && $stable(bank_open);
  endproperty
  a_sref_hold: assert property (p_sref_hold) else $error("self refresh left while cke low");

  property p_bst;
    @(posedge clk) disable iff (rst)
    (!sref_active && cmd == CMD_BST) |=> !s_q.bst_act ##2 dq_oe == '0;
  endproperty
  a_bst: assert property (p_bst) else $error("burst not terminated");

  property p_idle_cmd;
    @(posedge clk) disable iff (rst)
    (!sref_active && (cmd == CMD_INH || cmd == CMD_NOP) && s_q.bst_act && s_q.bst_left > 9'h001)
      |=> s_q.bst_act && $stable(mode_reg);
  endproperty
  a_idle_cmd: assert property (p_idle_cmd) else $error("idle command disturbed burst");

  property p_auto_close;
    @(posedge clk) disable iff (rst)
    (beat && b_left == 9'h001 && b_close && b_bank == 2'h1 && cmd != CMD_ACT) |=> !bank_open[1];
  endproperty
  a_auto_close: assert property (p_auto_close) else $error("auto close missed");

endmodule : sdc_core

// File: verif/sdc_ctl_model.sv
/*
  Behavioural memory controller driving the command pins of the core.
  Assumes the caller sits at a falling clock edge; all pins change there.
*/
`timescale 1ns/1ps
module sdc_ctl_model
  import sdc_pkg::*;
#(
  parameter int T_RP = 2,
  parameter int T_RC = 4
)
(
  // clock
  input wire logic clk,
  // controller pins
  output logic cke,
  output sdc_pins_t pins
);
  initial
  begin
    cke = 1'b1;
    pins = PINS_IDLE;
  end

  // released lines invert every cycle so stale values never look valid
  task automatic idle(input int n);
    repeat (n)
    begin
      pins = sdc_pins_t'{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: ~pins.ba,
        addr: ~pins.addr, dqm: 2'h0, dq: ~pins.dq};
      @(negedge clk);
    end
  endtask : idle

  // pins hold for one cycle; inhibit carries a precharge code to prove it is ignored
  task automatic issue(input sdc_cmd_t c, input logic [1:0] ba, input logic [11:0] a,
    input logic [1:0] m, input logic [15:0] d);
    logic [2:0] code;
    case (c)
      CMD_ACT: code = 3'h3;
      CMD_RD: code = 3'h5;
      CMD_WR: code = 3'h4;
      CMD_BST: code = 3'h6;
      CMD_PRE: code = 3'h2;
      CMD_REF: code = 3'h1;
      CMD_MRS: code = 3'h0;
      CMD_INH: code = 3'h2;
      default: code = 3'h7;
    endcase
    pins = sdc_pins_t'{cs_n: (c == CMD_INH), ras_n: code[2], cas_n: code[1], we_n: code[0],
      ba: ba, addr: a, dqm: m, dq: d};
    @(negedge clk);
    if (c == CMD_PRE)
      idle(T_RP);
    if (c == CMD_REF || c == CMD_MRS)
      idle(T_RC);
  endtask : issue

  task automatic sref_enter();
    cke = 1'b0;
    issue(CMD_REF, ~pins.ba, ~pins.addr, ~pins.dqm, ~pins.dq);
  endtask : sref_enter

  task automatic sref_exit();
    cke = 1'b1;
    idle(4 + T_RC);
  endtask : sref_exit

  task automatic refresh_all();
    // address lines keep changing so a counter that followed them would show
    repeat (4096) issue(CMD_REF, ~pins.ba, ~pins.addr, ~pins.dqm, ~pins.dq);
  endtask : refresh_all
endmodule : sdc_ctl_model

// File: verif/sdc_core_tb.sv
/*
  Self-checking bench for the command core, driven by the controller model.
  Assumes a 40 MHz clock and pins changing only at falling edges.
*/
`timescale 1ns/1ps
module sdc_core_tb
  import sdc_pkg::*;
;
  logic clk;
  logic rst;
  logic cke;
  sdc_pins_t pins;
  logic [DQ_W-1:0] dq_o;
  logic [BYTES-1:0] dq_oe;
  logic [BANKS-1:0] bank_open;
  logic sref_active;
  logic [ROW_W-1:0] mode_reg;
  logic [REF_W-1:0] refresh_addr;
  logic [REF_W-1:0] r0;
  int err_count = 0;
  int checks_done = 0;
  int n;

  sdc_core dut (.clk(clk), .rst(rst), .cke(cke), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe),
    .bank_open(bank_open), .sref_active(sref_active), .mode_reg(mode_reg),
    .refresh_addr(refresh_addr));
  sdc_ctl_model ctl (.clk(clk), .cke(cke), .pins(pins));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic ob(input logic [3:0] e);
    cmp("bank_open", {12'h000, e}, {12'h000, bank_open});
  endtask : ob

  task automatic sr(input logic e);
    cmp("sref_active", {15'h0000, e}, {15'h0000, sref_active});
  endtask : sr

  // status outputs settle a few cycles after the pipeline
  task automatic cmd(input sdc_cmd_t c, input logic [1:0] ba, input logic [11:0] a);
    ctl.issue(c, ba, a, ~pins.dqm, ~pins.dq);
    ctl.idle(4);
  endtask : cmd

  task automatic wr2(input logic [1:0] ba, input logic [11:0] a, input logic [1:0] m0,
    input logic [15:0] d0, input logic [1:0] m1, input logic [15:0] d1);
    ctl.issue(CMD_WR, ba, a, m0, d0);
    ctl.issue(CMD_NOP, ba, a, m1, d1);
    ctl.idle(4);
  endtask : wr2

  // floated lanes carry no defined data, so only driven lanes are compared
  task automatic beat(input logic [1:0] oe, input logic [15:0] d);
    logic [15:0] m;
    m = {{8{oe[1]}}, {8{oe[0]}}};
    ctl.idle(1);
    cmp("dq_oe", {14'h0000, oe}, {14'h0000, dq_oe});
    cmp("dq_o", d & m, dq_o & m);
  endtask : beat

  task automatic rd2(input logic [1:0] ba, input logic [11:0] a, input logic [1:0] m1,
    input logic [15:0] e0, input logic [15:0] e1);
    ctl.issue(CMD_RD, ba, a, 2'h0, 16'h0000);
    ctl.issue(CMD_NOP, ba, a, m1, 16'h0000);
    ctl.idle(1);
    beat(2'h3, e0);
    beat(~m1, e1);
    ctl.idle(4);
  endtask : rd2

  task automatic count_oe(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles)
    begin
      ctl.idle(1);
      if (dq_oe !== 2'h0)
        cnt++;
    end
  endtask : count_oe

  initial
  begin
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    ctl.idle(3);
    ob(4'h0);
    sr(1'b0);
    cmp("mode_reg", 16'h0000, {4'h0, mode_reg});
    cmp("refresh_addr", 16'h0000, {2'h0, refresh_addr});
    cmd(CMD_MRS, 2'h0, 12'h231);
    cmp("mode_reg", 16'h0231, {4'h0, mode_reg});
    cmd(CMD_ACT, 2'h1, 12'h123);
    cmd(CMD_ACT, 2'h2, 12'h456);
    ob(4'h6);
    ctl.issue(CMD_INH, 2'h1, 12'h400, 2'h0, 16'h0000);
    cmd(CMD_NOP, 2'h2, 12'h400);
    ob(4'h6);
    wr2(2'h1, 12'h0F0, 2'h0, 16'h2211, 2'h0, 16'h4433);
    wr2(2'h1, 12'h0F1, 2'h2, 16'hAAAA, 2'h1, 16'hBBBB);
    rd2(2'h1, 12'h0F0, 2'h1, 16'hBB11, 16'h44AA);
    ob(4'h6);
    wr2(2'h2, 12'h400, 2'h0, 16'h5A5A, 2'h0, 16'hA5A5);
    ob(4'h2);
    rd2(2'h1, 12'h4F1, 2'h0, 16'h44AA, 16'hBB11);
    ob(4'h0);
    cmd(CMD_ACT, 2'h0, 12'h001);
    cmd(CMD_ACT, 2'h3, 12'h002);
    cmd(CMD_PRE, 2'h0, 12'h000);
    ob(4'h8);
    cmd(CMD_ACT, 2'h1, 12'h003);
    cmd(CMD_PRE, 2'h2, 12'h400);
    ob(4'h0);
    ctl.issue(CMD_RD, 2'h0, 12'h000, 2'h0, 16'h0000);
    count_oe(8, n);
    cmp("idle_bank_beats", 16'h0000, n[15:0]);
    cmd(CMD_MRS, 2'h0, 12'h003);
    cmd(CMD_ACT, 2'h0, 12'h010);
    ctl.issue(CMD_RD, 2'h0, 12'h000, 2'h0, 16'h0000);
    ctl.issue(CMD_NOP, 2'h0, 12'h000, 2'h0, 16'h0000);
    ctl.issue(CMD_BST, 2'h0, 12'h000, 2'h0, 16'h0000);
    count_oe(12, n);
    cmp("cut_beats", 16'h0002, n[15:0]);
    cmd(CMD_PRE, 2'h0, 12'h400);
    // burst of four wraps inside its aligned block: written 6,7,4,5, read 5,6,7,4
    cmd(CMD_MRS, 2'h0, 12'h002);
    cmd(CMD_ACT, 2'h3, 12'h020);
    ctl.issue(CMD_WR, 2'h3, 12'h006, 2'h0, 16'h6666);
    ctl.issue(CMD_NOP, 2'h3, 12'h006, 2'h0, 16'h7777);
    ctl.issue(CMD_NOP, 2'h3, 12'h006, 2'h0, 16'h4444);
    ctl.issue(CMD_NOP, 2'h3, 12'h006, 2'h0, 16'h5555);
    ctl.idle(2);
    ctl.issue(CMD_RD, 2'h3, 12'h405, 2'h0, 16'h0000);
    ctl.issue(CMD_NOP, 2'h3, 12'h405, 2'h0, 16'h0000);
    ctl.issue(CMD_NOP, 2'h3, 12'h405, 2'h0, 16'h0000);
    beat(2'h3, 16'h5555);
    beat(2'h3, 16'h6666);
    beat(2'h3, 16'h7777);
    beat(2'h3, 16'h4444);
    ctl.idle(4);
    ob(4'h0);
    r0 = refresh_addr;
    cmd(CMD_REF, 2'h3, 12'hFFF);
    cmp("refresh_addr", {2'h0, r0 + 14'h0001}, {2'h0, refresh_addr});
    sr(1'b0);
    ctl.sref_enter();
    ctl.idle(4);
    sr(1'b1);
    r0 = refresh_addr;
    ctl.issue(CMD_ACT, 2'h3, 12'h111, 2'h0, 16'h0000);
    ctl.idle(700);
    ob(4'h0);
    cmp("sref_tick", 16'h0001, {15'h0000, refresh_addr !== r0});
    ctl.sref_exit();
    sr(1'b0);
    r0 = refresh_addr;
    ctl.refresh_all();
    cmp("refresh_addr", {2'h0, r0 + 14'h1000}, {2'h0, refresh_addr});
    results();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : sdc_core_tb
